// ---- logic/adc_pkg.sv ----
// Constants, field layout and types for the converter register front end
// Assumes one 20 MHz clock and a synchronous active-low reset
package adc_pkg;

  // Register select codes
  localparam logic [2:0] PTR_RESULT  = 3'h0;
  localparam logic [2:0] PTR_STATUS  = 3'h1;
  localparam logic [2:0] PTR_CONFIG  = 3'h2;
  localparam logic [2:0] PTR_LOW     = 3'h3;
  localparam logic [2:0] PTR_HIGH    = 3'h4;
  localparam logic [2:0] PTR_HYST    = 3'h5;
  localparam logic [2:0] PTR_LOWEST  = 3'h6;
  localparam logic [2:0] PTR_HIGHEST = 3'h7;

  // Field positions
  localparam int RES_LSB     = 2;
  localparam int RES_MSB     = 11;
  localparam int SUMMARY_BIT = 15;
  localparam int STAT_OVER   = 1;
  localparam int STAT_UNDER  = 0;
  localparam int CFG_HOLD    = 4;
  localparam int CFG_FLAG_EN = 3;
  localparam int CYC_LSB     = 5;
  localparam int CYC_MSB     = 7;

  // Writable bits of the configuration byte
  localparam logic [7:0] CFG_WMASK = 8'hfd;

  // Values after reset
  localparam logic [2:0] PTR_RESET     = 3'h0;
  localparam logic [9:0] RESULT_RESET  = 10'h000;
  localparam logic [1:0] STATUS_RESET  = 2'h0;
  localparam logic [7:0] CFG_RESET     = 8'h00;
  localparam logic [9:0] LOW_RESET     = 10'h000;
  localparam logic [9:0] HIGH_RESET    = 10'h3ff;
  localparam logic [9:0] HYST_RESET    = 10'h000;
  localparam logic [9:0] LOWEST_RESET  = 10'h3ff;
  localparam logic [9:0] HIGHEST_RESET = 10'h000;

  // Serial bus slave address, value arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h2a;

  // Bit count at which a byte is complete
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Finished conversion from the converter core
  typedef struct packed {
    logic       done;
    logic [9:0] code;
  } conv_type;

  // Serial slave states
  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WR_BYTE,
    ST_WR_ACK,
    ST_RD_BYTE,
    ST_RD_ACK
  } link_state_type;

endpackage : adc_pkg

// ---- logic/pin_sync.sv ----
// Two-stage synchroniser for the serial clock and data pins
// Assumes pins idle high, as on a pulled-up two-wire bus
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [1:0] async_in,
  output logic      [1:0] sync_out
);

  logic [1:0] meta_q;
  logic [1:0] stable_q;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_q   <= 2'h3;
      stable_q <= 2'h3;
    end else begin
      meta_q   <= async_in;
      stable_q <= meta_q;
    end
  end

  assign sync_out = stable_q;

endmodule : pin_sync
`default_nettype wire

// ---- logic/adc_reg_front.sv ----
// Register front end of a 10-bit converter behind a two-wire serial slave
// Assumes serial pins arrive asynchronously; conversion results on clk
//
// Function
// - Reset loads every register default, kept until conversion or write.
// - First finished conversion updates result and alert status.
// - Eight data registers plus pointer; result register is read-only.
// - First written data byte of a write lands in the pointer.
// - Pointer selects the register for following writes and reads.
// - Only pointer bits 2:0 select; upper bits must be written zero.
// - Pointer resets to zero, selecting the result register.
// - Select codes 0..7 map result, status, config, limits, hysteresis, extremes.
// - In normal mode each result register read starts a conversion.
// - Result sits in bits 11:2, straight binary; 14:12 and 1:0 zero.
// - Result register is 16-bit read-only and resets to zero.
// - Bit 15 high when flag enable set and any alert flag set.
// - Status register is 8-bit, resets zero, bits 7:2 read zero.
// - Alert flags are active high, one meaning a limit was violated.
// - Over-range flag bit 1 sets when code exceeds upper limit.
// - Under-range flag bit 0 sets when code falls below lower limit.
// - Over flag clears on write one, or below upper minus hysteresis.
// - Under flag clears on write one, or above lower plus hysteresis.
// - With hold set, flags clear only by writing one.
// - Config bit 3 enables the summary bit 15.
// - Config bit 4 is alert hold, blocking self-clear.
// - Limit registers keep 10-bit thresholds in bits 11:2, rest zero.
`timescale 1ns/1ps
`default_nettype none
module adc_reg_front (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             scl_pin,
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe,
  input  wire adc_pkg::conv_type conv,
  output logic                  conv_start
);

  logic [1:0]              pins_s;
  logic                    scl_s;
  logic                    sda_s;
  logic                    scl_p_q;
  logic                    sda_p_q;
  logic                    scl_rise;
  logic                    scl_fall;
  logic                    start_evt;
  logic                    stop_evt;
  adc_pkg::link_state_type state_q;
  logic [2:0]              cnt_q;
  logic                    full_q;
  logic [7:0]              sh_q;
  logic [7:0]              tx_q;
  logic                    oe_q;
  logic                    out_q;
  logic                    rw_q;
  logic                    ridx_q;
  logic                    nack_q;
  logic [1:0]              widx_q;
  logic [7:0]              hi_q;
  logic [2:0]              ptr_q;
  logic [9:0]              result_q;
  logic [1:0]              status_q;
  logic [7:0]              cfg_q;
  logic [9:0]              low_q;
  logic [9:0]              high_q;
  logic [9:0]              hyst_q;
  logic [9:0]              lowest_q;
  logic [9:0]              highest_q;
  logic                    start_q;
  logic                    addr_done;
  logic                    addr_hit;
  logic                    wr_done;
  logic                    is8;
  logic                    commit8;
  logic                    commit16;
  logic [15:0]             wdata16;
  logic [15:0]             sel_word;
  logic [7:0]              tx_next;
  logic                    summary;
  logic                    over_set;
  logic                    under_set;
  logic                    over_self;
  logic                    under_self;
  logic [1:0]              st_w1c;

  pin_sync u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in ({scl_pin, sda_in}),
    .sync_out (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Edge and bus condition detection
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_p_q;
  assign scl_fall  = ~scl_s & scl_p_q;
  assign start_evt = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_evt  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  assign addr_done = (state_q == adc_pkg::ST_ADDR) & full_q & scl_fall;
  assign addr_hit  = sh_q[7:1] == adc_pkg::DEV_ADDR;
  assign wr_done   = (state_q == adc_pkg::ST_WR_BYTE) & full_q & scl_fall;

  // Slave sequencing
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= adc_pkg::ST_IDLE;
    end else if (start_evt) begin
      state_q <= adc_pkg::ST_ADDR;
    end else if (stop_evt) begin
      state_q <= adc_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        adc_pkg::ST_IDLE: begin
          state_q <= adc_pkg::ST_IDLE;
        end
        adc_pkg::ST_ADDR: begin
          if (addr_done) begin
            state_q <= addr_hit ? adc_pkg::ST_ADDR_ACK : adc_pkg::ST_IDLE;
          end
        end
        adc_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            state_q <= rw_q ? adc_pkg::ST_RD_BYTE : adc_pkg::ST_WR_BYTE;
          end
        end
        adc_pkg::ST_WR_BYTE: begin
          if (wr_done) begin
            state_q <= adc_pkg::ST_WR_ACK;
          end
        end
        adc_pkg::ST_WR_ACK: begin
          if (scl_fall) begin
            state_q <= adc_pkg::ST_WR_BYTE;
          end
        end
        adc_pkg::ST_RD_BYTE: begin
          if (scl_fall && full_q) begin
            state_q <= adc_pkg::ST_RD_ACK;
          end
        end
        adc_pkg::ST_RD_ACK: begin
          if (scl_fall) begin
            state_q <= nack_q ? adc_pkg::ST_IDLE : adc_pkg::ST_RD_BYTE;
          end
        end
      endcase
    end
  end

  // Bit counting and receive shift
  always_ff @(posedge clk) begin
    if (!rst_b || start_evt || stop_evt) begin
      cnt_q  <= 3'h0;
      full_q <= 1'b0;
    end else if (scl_rise && (state_q == adc_pkg::ST_ADDR ||
                 state_q == adc_pkg::ST_WR_BYTE || state_q == adc_pkg::ST_RD_BYTE)) begin
      cnt_q  <= cnt_q + 3'h1;
      full_q <= cnt_q == adc_pkg::LAST_BIT;
    end else if (scl_fall && full_q) begin
      full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sh_q <= 8'h00;
    end else if (scl_rise && (state_q == adc_pkg::ST_ADDR ||
                 state_q == adc_pkg::ST_WR_BYTE)) begin
      sh_q <= {sh_q[6:0], sda_s};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rw_q   <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      if (addr_done) begin
        rw_q <= sh_q[0];
      end
      if (scl_rise && state_q == adc_pkg::ST_RD_ACK) begin
        nack_q <= sda_s;
      end
    end
  end

  // Register read selection
  assign summary = cfg_q[adc_pkg::CFG_FLAG_EN] & (|status_q);
  assign is8 = (ptr_q == adc_pkg::PTR_STATUS) | (ptr_q == adc_pkg::PTR_CONFIG);

  always_comb begin
    sel_word = 16'h0000;
    unique case (ptr_q)
      adc_pkg::PTR_RESULT:  sel_word = {summary, 3'h0, result_q, 2'h0};
      adc_pkg::PTR_STATUS:  sel_word = {14'h0000, status_q};
      adc_pkg::PTR_CONFIG:  sel_word = {8'h00, cfg_q};
      adc_pkg::PTR_LOW:     sel_word = {4'h0, low_q, 2'h0};
      adc_pkg::PTR_HIGH:    sel_word = {4'h0, high_q, 2'h0};
      adc_pkg::PTR_HYST:    sel_word = {4'h0, hyst_q, 2'h0};
      adc_pkg::PTR_LOWEST:  sel_word = {4'h0, lowest_q, 2'h0};
      adc_pkg::PTR_HIGHEST: sel_word = {4'h0, highest_q, 2'h0};
    endcase
  end

  // Upper byte first on 16-bit words
  assign tx_next = (is8 || ridx_q) ? sel_word[7:0] : sel_word[15:8];

  // Data line drive, open drain
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      oe_q   <= 1'b0;
      tx_q   <= 8'h00;
      ridx_q <= 1'b0;
    end else if (start_evt || stop_evt) begin
      oe_q <= 1'b0;
    end else if (addr_done) begin
      oe_q   <= addr_hit;
      ridx_q <= 1'b0;
    end else if (state_q == adc_pkg::ST_ADDR_ACK && scl_fall) begin
      if (rw_q) begin
        tx_q   <= tx_next;
        oe_q   <= ~tx_next[7];
        ridx_q <= ~ridx_q;
      end else begin
        oe_q <= 1'b0;
      end
    end else if (wr_done) begin
      oe_q <= 1'b1;
    end else if (state_q == adc_pkg::ST_WR_ACK && scl_fall) begin
      oe_q <= 1'b0;
    end else if (state_q == adc_pkg::ST_RD_BYTE && scl_fall) begin
      if (full_q) begin
        oe_q <= 1'b0;
      end else begin
        tx_q <= {tx_q[6:0], 1'b0};
        oe_q <= ~tx_q[6];
      end
    end else if (state_q == adc_pkg::ST_RD_ACK && scl_fall && !nack_q) begin
      tx_q   <= tx_next;
      oe_q   <= ~tx_next[7];
      ridx_q <= ~ridx_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      out_q <= 1'b0;
    end else begin
      out_q <= 1'b0;
    end
  end

  // Write byte bookkeeping
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      widx_q <= 2'h0;
      hi_q   <= 8'h00;
    end else if (addr_done) begin
      widx_q <= 2'h0;
    end else if (wr_done) begin
      if (widx_q != 2'h3) begin
        widx_q <= widx_q + 2'h1;
      end
      if (widx_q == 2'h1) begin
        hi_q <= sh_q;
      end
    end
  end

  assign commit8  = wr_done & (widx_q == 2'h1) & is8;
  assign commit16 = wr_done & (widx_q == 2'h2) & ~is8;
  assign wdata16  = {hi_q, sh_q};

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ptr_q <= adc_pkg::PTR_RESET;
    end else if (wr_done && widx_q == 2'h0) begin
      ptr_q <= sh_q[2:0];
    end
  end

  // Writable registers; result has no write path
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cfg_q     <= adc_pkg::CFG_RESET;
      low_q     <= adc_pkg::LOW_RESET;
      high_q    <= adc_pkg::HIGH_RESET;
      hyst_q    <= adc_pkg::HYST_RESET;
      lowest_q  <= adc_pkg::LOWEST_RESET;
      highest_q <= adc_pkg::HIGHEST_RESET;
    end else begin
      if (commit8 && ptr_q == adc_pkg::PTR_CONFIG) begin
        cfg_q <= sh_q & adc_pkg::CFG_WMASK;
      end
      if (commit16) begin
        unique case (ptr_q)
          adc_pkg::PTR_LOW:     low_q     <= wdata16[adc_pkg::RES_MSB:adc_pkg::RES_LSB];
          adc_pkg::PTR_HIGH:    high_q    <= wdata16[adc_pkg::RES_MSB:adc_pkg::RES_LSB];
          adc_pkg::PTR_HYST:    hyst_q    <= wdata16[adc_pkg::RES_MSB:adc_pkg::RES_LSB];
          adc_pkg::PTR_LOWEST:  lowest_q  <= wdata16[adc_pkg::RES_MSB:adc_pkg::RES_LSB];
          adc_pkg::PTR_HIGHEST: highest_q <= wdata16[adc_pkg::RES_MSB:adc_pkg::RES_LSB];
          default: ;
        endcase
      end
    end
  end

  // Conversion result and limit checks
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      result_q <= adc_pkg::RESULT_RESET;
    end else if (conv.done) begin
      result_q <= conv.code;
    end
  end

  assign over_set   = conv.done & (conv.code > high_q);
  assign under_set  = conv.done & (conv.code < low_q);
  assign over_self  = conv.done & ~cfg_q[adc_pkg::CFG_HOLD] &
                      (({1'b0, conv.code} + {1'b0, hyst_q}) < {1'b0, high_q});
  assign under_self = conv.done & ~cfg_q[adc_pkg::CFG_HOLD] &
                      ({1'b0, conv.code} > ({1'b0, low_q} + {1'b0, hyst_q}));
  assign st_w1c = (commit8 && ptr_q == adc_pkg::PTR_STATUS) ? sh_q[1:0] : 2'h0;

  // Set wins over any clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      status_q <= adc_pkg::STATUS_RESET;
    end else begin
      status_q[adc_pkg::STAT_OVER] <= over_set | (status_q[adc_pkg::STAT_OVER] &
        ~(st_w1c[adc_pkg::STAT_OVER] | over_self));
      status_q[adc_pkg::STAT_UNDER] <= under_set | (status_q[adc_pkg::STAT_UNDER] &
        ~(st_w1c[adc_pkg::STAT_UNDER] | under_self));
    end
  end

  // Normal-mode conversion request on a result read
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      start_q <= 1'b0;
    end else begin
      start_q <= addr_done & addr_hit & sh_q[0] & (ptr_q == adc_pkg::PTR_RESULT) &
                 (cfg_q[adc_pkg::CYC_MSB:adc_pkg::CYC_LSB] == 3'h0);
    end
  end

  assign sda_out    = out_q;
  assign sda_oe     = oe_q;
  assign conv_start = start_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_result_read;
    addr_done && addr_hit && sh_q[0] && ptr_q == adc_pkg::PTR_RESULT &&
    cfg_q[adc_pkg::CYC_MSB:adc_pkg::CYC_LSB] == 3'h0;
  endsequence

  sequence s_one_pulse;
    start_q ##1 !start_q;
  endsequence

  a_reset_defaults: assert property (!$past(rst_b) |->
    ptr_q == 3'h0 && result_q == 10'h000 && status_q == 2'h0 && high_q == 10'h3ff)
    else $error("register default missing after reset");
  a_conv_update: assert property (conv.done |=> result_q == $past(conv.code))
    else $error("result not updated by conversion");
  a_pointer_capture: assert property (wr_done && widx_q == 2'h0 |=>
    ptr_q == $past(sh_q[2:0]) && widx_q == 2'h1)
    else $error("pointer byte not captured");
  a_read_start: assert property (s_result_read |=> s_one_pulse)
    else $error("result read did not start one conversion");
  a_result_layout: assert property (ptr_q == adc_pkg::PTR_RESULT |->
    sel_word[14:12] == 3'h0 && sel_word[1:0] == 2'h0 && sel_word[11:2] == result_q)
    else $error("result word layout wrong");
  a_summary_bit: assert property (ptr_q == adc_pkg::PTR_RESULT |->
    sel_word[15] == (cfg_q[3] && status_q != 2'h0))
    else $error("summary bit wrong");
  a_over_set: assert property (conv.done && conv.code > high_q |=> status_q[1])
    else $error("over flag not set");
  a_under_set: assert property (conv.done && conv.code < low_q |=> status_q[0])
    else $error("under flag not set");
  a_over_w1c: assert property (status_q[1] && st_w1c[1] && !over_set |=> !status_q[1])
    else $error("over flag not cleared by write");
  a_under_self: assert property (status_q[0] && conv.done && !cfg_q[4] &&
    conv.code > low_q + hyst_q && conv.code >= low_q && low_q + hyst_q >= low_q
    |=> !status_q[0])
    else $error("under flag did not self clear");
  a_hold_keeps: assert property (cfg_q[4] && status_q == 2'h3 && st_w1c == 2'h0
    |=> status_q == 2'h3)
    else $error("flag self cleared under hold");

endmodule : adc_reg_front
`default_nettype wire

// ---- tb/bus_ctl_model.sv ----
// Two-wire bus controller model: start, stop, byte write and byte read
// Assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/1ps
`default_nettype none
module bus_ctl_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_oe
);
  initial begin
    scl    = 1'b1;
    sda_oe = 1'b0;
  end

  // Half of the 400 ns bus clock period
  task automatic h;
    repeat (4) @(negedge clk);
  endtask : h

  task automatic start;
    sda_oe = 1'b0;
    h();
    scl = 1'b1;
    h();
    sda_oe = 1'b1;
    h();
    scl = 1'b0;
  endtask : start

  task automatic stop;
    sda_oe = 1'b1;
    h();
    scl = 1'b1;
    h();
    sda_oe = 1'b0;
    h();
  endtask : stop

  task automatic bit_out(input logic b);
    sda_oe = ~b;
    h();
    scl = 1'b1;
    h();
    scl = 1'b0;
  endtask : bit_out

  task automatic bit_in(output logic v);
    sda_oe = 1'b0;
    h();
    scl = 1'b1;
    h();
    v   = sda;
    scl = 1'b0;
  endtask : bit_in

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      bit_out(b[i]);
    end
    bit_in(v);
    ack = ~v;
  endtask : wbyte

  task automatic rbyte(input logic more, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      bit_in(b[i]);
    end
    bit_out(~more);
  endtask : rbyte
endmodule : bus_ctl_model
`default_nettype wire

// ---- tb/adc_pointer_result_alert_regs_test.sv ----
// Self-checking bench for the converter register front end
// Assumes the controller model drives the bus; bench drives conversions
`timescale 1ns/1ps
`default_nettype none
module adc_pointer_result_alert_regs_test;
  typedef struct {
    logic [7:0]  ptr;
    int          n;
    logic [15:0] wd;
    logic [15:0] ex;
  } row_type;
  typedef struct {
    logic [9:0]  code;
    logic [15:0] st;
    logic [15:0] res;
  } conv_row_type;

  logic              clk;
  logic              rst_b;
  logic              scl;
  logic              sda;
  logic              dev_oe;
  logic              ctl_oe;
  logic              sda_out;
  logic              conv_start;
  adc_pkg::conv_type conv;
  int                err_total;
  int                n_checks;
  int                starts;
  int                s0;
  logic [15:0]       rd;
  logic              ack;

  row_type rows [8] = '{
    '{8'h02, 1, 16'h00ff, 16'h00fd}, '{8'h03, 2, 16'h0ffc, 16'h0ffc},
    '{8'h04, 2, 16'h0c00, 16'h0c00}, '{8'h05, 2, 16'h0040, 16'h0040},
    '{8'h06, 2, 16'h0234, 16'h0234}, '{8'h07, 2, 16'h0ffc, 16'h0ffc},
    '{8'h00, 2, 16'hffff, 16'h0000}, '{8'h01, 1, 16'h0003, 16'h0000}};
  conv_row_type cv [6] = '{
    '{10'h350, 16'h0002, 16'h8d40}, '{10'h2f8, 16'h0002, 16'h8be0},
    '{10'h2e0, 16'h0000, 16'h0b80}, '{10'h050, 16'h0001, 16'h8140},
    '{10'h108, 16'h0001, 16'h8420}, '{10'h111, 16'h0000, 16'h0444}};

  assign sda = ~(dev_oe | ctl_oe);

  adc_reg_front dut (
    .clk       (clk),
    .rst_b     (rst_b),
    .scl_pin   (scl),
    .sda_in    (sda),
    .sda_out   (sda_out),
    .sda_oe    (dev_oe),
    .conv      (conv),
    .conv_start(conv_start)
  );

  bus_ctl_model ctl (
    .clk   (clk),
    .sda   (sda),
    .scl   (scl),
    .sda_oe(ctl_oe)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (conv_start === 1'b1) begin
      starts++;
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wb(input logic [7:0] b);
    ctl.wbyte(b, ack);
    chk({15'h0, ack}, 16'h0001);
  endtask : wb

  task automatic wr(input logic [7:0] ptr, input logic [15:0] d, input int n);
    ctl.start();
    wb({adc_pkg::DEV_ADDR, 1'b0});
    wb(ptr);
    if (n == 2) begin
      wb(d[15:8]);
    end
    wb(d[7:0]);
    ctl.stop();
  endtask : wr

  task automatic rd16(input logic set, input logic [7:0] ptr, input int n,
                      output logic [15:0] d);
    logic [7:0] hi;
    logic [7:0] lo;
    hi = 8'h00;
    if (set) begin
      ctl.start();
      wb({adc_pkg::DEV_ADDR, 1'b0});
      wb(ptr);
    end
    ctl.start();
    wb({adc_pkg::DEV_ADDR, 1'b1});
    if (n == 2) begin
      ctl.rbyte(1'b1, hi);
    end
    ctl.rbyte(1'b0, lo);
    ctl.stop();
    d = {hi, lo};
  endtask : rd16

  task automatic convert(input logic [9:0] c);
    @(negedge clk);
    conv = '{1'b1, c};
    @(negedge clk);
    conv.done = 1'b0;
    repeat (2) @(negedge clk);
  endtask : convert

  task automatic do_reset;
    rst_b = 1'b0;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
  endtask : do_reset

  task automatic complete_run;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    complete_run();
  end

  initial begin
    rst_b     = 1'b0;
    conv      = '0;
    err_total = 0;
    n_checks  = 0;
    starts    = 0;
    do_reset();
    s0 = starts;
    rd16(1'b0, 8'h00, 2, rd);
    chk(rd, 16'h0000);
    chk(16'(starts - s0), 16'h0001);
    rd16(1'b1, 8'h01, 1, rd);
    chk(rd, 16'h0000);
    chk(16'(starts - s0), 16'h0001);
    for (int i = 0; i < 8; i++) begin
      wr(rows[i].ptr, rows[i].wd, rows[i].n);
      rd16(1'b1, rows[i].ptr, rows[i].n, rd);
      chk(rd, rows[i].ex);
    end
    wr(8'h02, 16'h0008, 1);
    wr(8'h03, 16'h0400, 2);
    for (int i = 0; i < 6; i++) begin
      convert(cv[i].code);
      rd16(1'b1, 8'h01, 1, rd);
      chk(rd, cv[i].st);
      rd16(1'b1, 8'h00, 2, rd);
      chk(rd, cv[i].res);
    end
    wr(8'h02, 16'h0018, 1);
    convert(10'h350);
    convert(10'h000);
    rd16(1'b1, 8'h01, 1, rd);
    chk(rd, 16'h0003);
    wr(8'h01, 16'h0002, 1);
    rd16(1'b0, 8'h00, 1, rd);
    chk(rd, 16'h0001);
    wr(8'h02, 16'h0010, 1);
    rd16(1'b1, 8'h00, 2, rd);
    chk(rd, 16'h0000);
    wr(8'h01, 16'h0001, 1);
    rd16(1'b1, 8'h01, 1, rd);
    chk(rd, 16'h0000);
    wr(8'h04, 16'h0400, 2);
    do_reset();
    rd16(1'b0, 8'h00, 2, rd);
    chk(rd, 16'h0000);
    rd16(1'b1, 8'h04, 2, rd);
    chk(rd, 16'h0ffc);
    convert(10'h123);
    rd16(1'b1, 8'h00, 2, rd);
    chk(rd, 16'h048c);
    chk({15'h0000, sda_out}, 16'h0000);
    complete_run();
  end
endmodule : adc_pointer_result_alert_regs_test
`default_nettype wire
